//--- nco_defs.vh
// register map, field positions and reset values of the numeric oscillator core
`ifndef NCO_DEFS_VH
`define NCO_DEFS_VH
`define NCO_ADR_W        6
`define NCO_OFS_CTRL     6'h00
`define NCO_OFS_CLKCFG   6'h04
`define NCO_OFS_ACCL     6'h08
`define NCO_OFS_ACCH     6'h0c
`define NCO_OFS_ACCU     6'h10
`define NCO_OFS_INCL     6'h14
`define NCO_OFS_INCH     6'h18
`define NCO_OFS_INCU     6'h1c
`define NCO_OFS_IRQ      6'h20
`define NCO_BIT_EN       7
`define NCO_BIT_OUT      5
`define NCO_BIT_POL      4
`define NCO_BIT_PFM      0
`define NCO_PWS_HI       7
`define NCO_PWS_LO       5
`define NCO_CKS_HI       1
`define NCO_CKS_LO       0
`define NCO_IRQ_FLAG     0
`define NCO_IRQ_EN       1
`define NCO_IRQ_PERIPHERAL_IRQ_ENABLE     2
`define NCO_IRQ_GIE      3
`define NCO_CKS_HFINT    2'h0
`define NCO_CKS_SYS      2'h1
`define NCO_CKS_LC3      2'h2
`define NCO_RST_VAL      8'h00
`define NCO_LOAD_EDGES   2'h2
`endif

//--- nco_core.v
// numeric oscillator core with wishbone register slave
// Overview of operation
// - 20-bit accumulator readable, writable as three bytes
// - each rising input clock edge adds buffered increment
// - adder carry is the overflow event
// - 20-bit increment held in three bytes
// - low byte write loads buffers second edge
// - disabled: increment writes load buffers immediately
// - buffers hidden; reads return written values
// - fixed-duty mode toggles output per overflow
// - mode bit set selects pulse mode
// - pulse mode: active edge after overflow
// - width code selects 1 to 128 periods
// - polarity bit inverts output as last stage
// - polarity change raises interrupt when enabled
// - status bit shows current output level
// - overflow sets sticky flag; four enables gate request
// - enable bit turns oscillator on
// - two-bit field selects input clock source
// - reset clears every register to zero
// - runs in sleep; keeps internal oscillator requested while enabled with that source selected

// register map, one byte each on lane 0, upper lanes read zero
//   0x00 control
//        bit 7   module enable
//        bit 5   output level, read only
//        bit 4   output polarity, set inverts
//        bit 0   pulse mode select
//   0x04 clock and pulse config
//        bits 7:5 pulse width code
//        bits 1:0 input clock source
//   0x08 accumulator low
//   0x0c accumulator high
//   0x10 accumulator upper, bits 3:0
//   0x14 increment low, write last when running
//   0x18 increment high
//   0x1c increment upper, bits 3:0
//   0x20 interrupt control
//        bit 3   global enable
//        bit 2   peripheral enable
//        bit 1   overflow enable
//        bit 0   overflow flag, write zero clears
// any other offset answers with err and changes nothing

// timing notes
//   source clocks pass two flops, then an edge detector,
//   so each must stay well below half the bus clock
//   an overflow reaches the flag a few bus cycles late
//   pulse widths count source periods, not bus cycles
//   a width longer than the overflow period gives a ragged output
//   stopping the module drops a pending buffer load and pulse
//   the toggle state survives a stop, so the level may resume high
//   clock enable low freezes every flop, the bus answer included
//   accumulator writes win over an addition in the same cycle
//   and also suppress that cycle's overflow flag
//   increment reads return the software copy, never the buffer
//   the reserved source code stops all additions
//   the flag is also set by any output level change while
//   the overflow enable is set, which covers polarity flips
//   the sleep hold request is the only link to clock control
//   no interrupt logic lives here beyond the flag and its gate
//   sel lane 0 must be set for a write to land;
//   other lanes are ignored and still acknowledged
//   read data stands only in the ack cycle
//   a new request needs the previous ack gone
`include "nco_defs.vh"
module nco_core (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        hf_osc_clk_i,
    input  wire        sys_osc_clk_i,
    input  wire        logic_cell3_output_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    output reg         nco_out_o,
    output reg         irq_o,
    output reg         hf_osc_keep_o
);
    // control registers
    reg        module_enable;
    reg        output_polarity;
    reg        pulse_mode_select;
    reg [2:0]  pulse_width_select;
    reg [1:0]  input_clock_select;
    reg [19:0] acc;
    reg [19:0] inc_reg;
    reg [19:0] inc_buf;
    reg        overflow_irq_flag;
    reg        overflow_irq_enable;
    reg        peripheral_irq_enable;
    reg        global_irq_enable;
    // oscillator state
    reg [2:0]  sync_hf;
    reg [2:0]  sync_sys;
    reg [2:0]  sync_lc3;
    reg        carry_pend;
    reg        toggle_q;
    reg        pulse_act;
    reg [7:0]  pulse_cnt;
    reg        load_pend;
    reg [1:0]  load_cnt;
    reg        prev_out;
    // combinational helpers
    reg        osc_edge;
    reg [20:0] sum;
    reg        raw_out;
    reg        lvl;
    reg [7:0]  width;
    reg        wr_acc;
    reg        wr_inc;
    reg [31:0] rd;
    reg        hit;
    wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire       wr  = req & wb_we_i & wb_sel_i[0];
    wire [5:0] adr = wb_adr_i[5:0];
    wire [7:0] wd  = wb_dat_i[7:0];
    // one write strobe per register keeps the clocked processes small
    wire       wr_ctrl   = wr & (adr == `NCO_OFS_CTRL);
    wire       wr_clkcfg = wr & (adr == `NCO_OFS_CLKCFG);
    wire       wr_accl   = wr & (adr == `NCO_OFS_ACCL);
    wire       wr_acch   = wr & (adr == `NCO_OFS_ACCH);
    wire       wr_accu   = wr & (adr == `NCO_OFS_ACCU);
    wire       wr_incl   = wr & (adr == `NCO_OFS_INCL);
    wire       wr_inch   = wr & (adr == `NCO_OFS_INCH);
    wire       wr_incu   = wr & (adr == `NCO_OFS_INCU);
    wire       wr_irq    = wr & (adr == `NCO_OFS_IRQ);

    // edge detect compares second- and third-stage samples; first stage feeds nothing else
    always @* begin
        case (input_clock_select)
            `NCO_CKS_HFINT: osc_edge = sync_hf[1] & ~sync_hf[2];
            `NCO_CKS_SYS:   osc_edge = sync_sys[1] & ~sync_sys[2];
            `NCO_CKS_LC3:   osc_edge = sync_lc3[1] & ~sync_lc3[2];
            default:        osc_edge = 1'b0; // reserved source never clocks
        endcase
    end

    // adder and output shaping
    always @* begin
        sum = {1'b0, acc} + {1'b0, inc_buf};
        width = 8'h01 << pulse_width_select;
        raw_out = pulse_mode_select ? pulse_act : toggle_q;
        lvl = raw_out ^ output_polarity;
        wr_acc = wr & ((adr == `NCO_OFS_ACCL) | (adr == `NCO_OFS_ACCH) | (adr == `NCO_OFS_ACCU));
        wr_inc = wr & ((adr == `NCO_OFS_INCL) | (adr == `NCO_OFS_INCH) | (adr == `NCO_OFS_INCU));
    end

    // read mux; unmapped addresses answer with err
    always @* begin
        rd = 32'h00000000;
        hit = 1'b1;
        case (adr)
            `NCO_OFS_CTRL:   rd[7:0] = {module_enable, 1'b0, nco_out_o, output_polarity,
                                        3'h0, pulse_mode_select};
            `NCO_OFS_CLKCFG: rd[7:0] = {pulse_width_select, 3'h0, input_clock_select};
            `NCO_OFS_ACCL:   rd[7:0] = acc[7:0];
            `NCO_OFS_ACCH:   rd[7:0] = acc[15:8];
            `NCO_OFS_ACCU:   rd[7:0] = {4'h0, acc[19:16]};
            `NCO_OFS_INCL:   rd[7:0] = inc_reg[7:0];
            `NCO_OFS_INCH:   rd[7:0] = inc_reg[15:8];
            `NCO_OFS_INCU:   rd[7:0] = {4'h0, inc_reg[19:16]};
            `NCO_OFS_IRQ:    rd[7:0] = {4'h0, global_irq_enable, peripheral_irq_enable,
                                        overflow_irq_enable, overflow_irq_flag};
            default:         hit = 1'b0;
        endcase
    end

    // input synchronisers; a source clock is never read before its second flop
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_hf <= 3'h0;
            sync_sys <= 3'h0;
            sync_lc3 <= 3'h0;
        end else if (ce_i) begin
            sync_hf <= {sync_hf[1:0], hf_osc_clk_i};
            sync_sys <= {sync_sys[1:0], sys_osc_clk_i};
            sync_lc3 <= {sync_lc3[1:0], logic_cell3_output_i};
        end
    end

    // bus answer one cycle after the request, dropped in the next cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            wb_dat_o <= rd; // only meaningful while ack is high
        end
    end

    // control fields; read-only and unimplemented bits are dropped here
    always @(posedge clk_i) begin
        if (rst_i) begin
            module_enable <= 1'b0;
            output_polarity <= 1'b0;
            pulse_mode_select <= 1'b0;
            pulse_width_select <= 3'h0;
            input_clock_select <= 2'h0;
            overflow_irq_enable <= 1'b0;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                module_enable <= wd[`NCO_BIT_EN];
                output_polarity <= wd[`NCO_BIT_POL];
                pulse_mode_select <= wd[`NCO_BIT_PFM];
            end
            if (wr_clkcfg) begin
                pulse_width_select <= wd[`NCO_PWS_HI:`NCO_PWS_LO];
                input_clock_select <= wd[`NCO_CKS_HI:`NCO_CKS_LO];
            end
            if (wr_irq) begin
                overflow_irq_enable <= wd[`NCO_IRQ_EN];
                peripheral_irq_enable <= wd[`NCO_IRQ_PERIPHERAL_IRQ_ENABLE];
                global_irq_enable <= wd[`NCO_IRQ_GIE];
            end
        end
    end

    // software copy of the increment; reads always return this copy
    always @(posedge clk_i) begin
        if (rst_i) begin
            inc_reg <= 20'h00000;
        end else if (ce_i) begin
            if (wr_incl)
                inc_reg[7:0] <= wd;
            if (wr_inch)
                inc_reg[15:8] <= wd;
            if (wr_incu)
                inc_reg[19:16] <= wd[3:0];
        end
    end

    // accumulator; a software write wins over an addition in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc <= 20'h00000;
            carry_pend <= 1'b0;
        end else if (ce_i) begin
            if (module_enable && osc_edge) begin
                acc <= sum[19:0];
                carry_pend <= sum[20];
            end
            if (!module_enable)
                carry_pend <= 1'b0;
            if (wr_accl)
                acc[7:0] <= wd;
            if (wr_acch)
                acc[15:8] <= wd;
            if (wr_accu)
                acc[19:16] <= wd[3:0];
        end
    end

    // output shaping: toggle in fixed-duty mode, counted pulse in pulse mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            toggle_q <= 1'b0;
            pulse_act <= 1'b0;
            pulse_cnt <= 8'h00;
        end else if (ce_i) begin
            if (module_enable && osc_edge) begin
                if (sum[20] && !pulse_mode_select)
                    toggle_q <= ~toggle_q;
                if (carry_pend && pulse_mode_select) begin
                    pulse_act <= 1'b1;
                    pulse_cnt <= width - 8'h01;
                end else if (pulse_act) begin
                    if (pulse_cnt == 8'h00)
                        pulse_act <= 1'b0;
                    else
                        pulse_cnt <= pulse_cnt - 8'h01;
                end
            end
            if (!module_enable)
                pulse_act <= 1'b0;
        end
    end

    // hidden buffer: immediate when stopped, two source edges late when running
    always @(posedge clk_i) begin
        if (rst_i) begin
            inc_buf <= 20'h00000;
            load_pend <= 1'b0;
            load_cnt <= 2'h0;
        end else if (ce_i) begin
            if (module_enable && osc_edge && load_pend) begin
                if (load_cnt == `NCO_LOAD_EDGES - 2'h1) begin
                    inc_buf <= inc_reg;
                    load_pend <= 1'b0;
                end
                load_cnt <= load_cnt + 2'h1;
            end
            if (!module_enable)
                load_pend <= 1'b0;
            if (!module_enable && wr_incl)
                inc_buf[7:0] <= wd;
            if (!module_enable && wr_inch)
                inc_buf[15:8] <= wd;
            if (!module_enable && wr_incu)
                inc_buf[19:16] <= wd[3:0];
            if (module_enable && wr_incl) begin
                load_pend <= 1'b1;
                load_cnt <= 2'h0;
            end
        end
    end

    // sticky flag and registered outputs; an event in the clearing cycle wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            overflow_irq_flag <= 1'b0;
            prev_out <= 1'b0;
            nco_out_o <= 1'b0;
            irq_o <= 1'b0;
            hf_osc_keep_o <= 1'b0;
        end else if (ce_i) begin
            if (module_enable && osc_edge && sum[20] && !wr_acc)
                overflow_irq_flag <= 1'b1;
            else if (prev_out != lvl && overflow_irq_enable)
                overflow_irq_flag <= 1'b1;
            else if (wr_irq)
                overflow_irq_flag <= wd[`NCO_IRQ_FLAG];
            prev_out <= lvl;
            nco_out_o <= lvl;
            irq_o <= overflow_irq_flag & module_enable & overflow_irq_enable
                     & peripheral_irq_enable & global_irq_enable;
            hf_osc_keep_o <= module_enable & (input_clock_select == `NCO_CKS_HFINT);
        end
    end
endmodule

//--- nco_props.sv
// port checker for the numeric oscillator core
module nco_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        nco_out_o,
    input wire logic        irq_o,
    input wire logic        hf_osc_keep_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a write to control that clears the enable bit, seen one cycle late
    logic off_wr = 1'b0;
    always @(posedge clk_i)
        off_wr <= wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i[5:0] == 6'h00 && !wb_dat_i[7];
    a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_req_answer: assert property ($rose(wb_stb_i) && ce_i |=> wb_ack_o || wb_err_o) else $error("late answer");
    a_unmapped_err: assert property ($rose(wb_stb_i) && wb_adr_i[5:0] > 6'h20 |=> wb_err_o) else $error("no err");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_status_read: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[5:0] == 6'h00)
        && $stable(nco_out_o) |-> wb_dat_o[5] == nco_out_o) else $error("status differs from output");
    a_irq_off: assert property (wb_ack_o && off_wr |-> ##[0:2] !irq_o) else $error("irq while off");
    a_keep_off: assert property (wb_ack_o && off_wr |-> ##[0:2] !hf_osc_keep_o) else $error("keep while off");
    // reset must clear outputs, so this one is not disabled by it
    a_reset_clear: assert property (disable iff (1'b0) rst_i && ce_i |=> !nco_out_o && !irq_o
        && !wb_ack_o && !hf_osc_keep_o) else $error("output not cleared by reset");
    c_err: cover property (wb_err_o);
    c_irq: cover property ($rose(irq_o));
    c_out: cover property ($fell(nco_out_o));
endmodule
bind nco_core nco_props CHK (.clk_i, .rst_i, .ce_i, .wb_stb_i, .wb_cyc_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .nco_out_o, .irq_o, .hf_osc_keep_o);

//--- nco_clk_src.sv
// input clock source model for the oscillator's selectable clocks
module nco_clk_src (
    input  wire logic       clk_i,
    input  wire logic [1:0] sel_i,
    output wire logic       hf_o,
    output wire logic       sys_o,
    output wire logic       lc3_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ck = 1'b0;
    // n periods of eight system cycles, then the source stops low
    task automatic burst(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_i);
            ck <= 1'b1;
            repeat (4) @(posedge clk_i);
            ck <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
    endtask
    // only the chosen line moves; the reserved code gets no clock at all
    assign hf_o  = ck && (sel_i == 2'h0);
    assign sys_o = ck && (sel_i == 2'h1);
    assign lc3_o = ck && (sel_i == 2'h2);
endmodule

//--- testbench.sv
// self-checking bench for the numeric oscillator core
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, e, last = 1'b0, tq = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o;
    logic [1:0]  sel = 2'h0;
    logic [7:0]  q, v;
    logic [19:0] acc;
    logic        hf, sy, lc, ack, err, out, irq, keep;
    int          fail_count = 0, check_count = 0, chg = 0, hi = 0, seed = 32'h6625, dc, dh;
    logic [7:0]  mask [9] = '{8'h01, 8'he3, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'h0f};
    longint      inc, ov;
    nco_clk_src SRC (.clk_i(clk_i), .sel_i(sel), .hf_o(hf), .sys_o(sy), .lc3_o(lc));
    nco_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .hf_osc_clk_i(hf), .sys_osc_clk_i(sy),
        .logic_cell3_output_i(lc), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .nco_out_o(out), .irq_o(irq), .hf_osc_keep_o(keep));
    initial forever #5 clk_i = ~clk_i;
    // output edges and active cycles, read as differences
    always @(posedge clk_i) begin
        chg <= chg + (out !== last);
        hi <= hi + (out === 1'b1);
        last <= out;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; request held until ack or err is seen
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {26'h0, a};
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (!(ack || err) && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        q = dat_o[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n == 20) fail_count++;
    endtask
    // upper byte first, low byte last keeps the value coherent
    task automatic set20(input logic [5:0] b, input logic [19:0] x);
        bus(1'b1, b + 6'h08, {4'h0, x[19:16]});
        bus(1'b1, b + 6'h04, x[15:8]);
        bus(1'b1, b, x[7:0]);
    endtask
    // one timed run from a cleared accumulator, then stop and read back
    task automatic run(input logic m, input logic [7:0] cfg, input longint ic, input int n);
        bus(1'b1, 6'h10, 8'h00);
        set20(6'h08, 20'h0);
        set20(6'h14, ic[19:0]);
        bus(1'b1, 6'h04, cfg);
        bus(1'b1, 6'h20, 8'h0e);
        bus(1'b1, 6'h00, {7'h40, m});
        sel <= cfg[1:0];
        @(posedge clk_i); // let a mode switch settle before counting
        dc = chg;
        dh = hi;
        SRC.burst(n);
        dc = chg - dc;
        dh = hi - dh;
        ov = (cfg[1:0] == 2'h3) ? 0 : (n * ic) >> 20;
        if (!m) tq ^= ov[0];
        chk(keep, cfg[1:0] == 2'h0);
        if (!m) chk(dc, ov);
        chk(irq, ov != 0);
        bus(1'b1, 6'h00, 8'h00);
        chk(irq, 0);
        bus(1'b0, 6'h08, 8'h0);
        acc[7:0] = q;
        bus(1'b0, 6'h0c, 8'h0);
        acc[15:8] = q;
        bus(1'b0, 6'h10, 8'h0);
        acc[19:16] = q[3:0];
        chk(acc, (cfg[1:0] == 2'h3) ? 0 : (n * ic) % (1 << 20));
    endtask
    task automatic end_sim;
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, then random writes through the access masks
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, i * 4, 8'h00);
            chk(q, 0);
            v = $random(seed) & mask[i];
            bus(1'b1, i * 4, v);
            bus(1'b0, i * 4, 8'h00);
            chk(q, v);
        end
        bus(1'b0, 6'h24, 8'h00);
        chk(e, 1);
        // every source code in fixed-duty mode with a random increment
        for (int k = 0; k < 4; k++) begin
            inc = $random(seed) & 20'hfffff;
            run(1'b0, k, inc, 20);
        end
        // each width code, overflow period twice the width
        for (int c = 0; c < 8; c++) begin
            run(1'b1, {c[2:0], 5'h01}, 1 << (19 - c), 3 * (1 << c) + 1);
            chk(dc, 2);
            chk(dh, 8 << c);
        end
        bus(1'b1, 6'h20, 8'h0e);
        bus(1'b1, 6'h00, 8'h90);
        bus(1'b0, 6'h00, 8'h00);
        chk(q[5], !tq);
        chk(out, !tq);
        chk(irq, 1);
        end_sim;
    end
endmodule
